// file: rtl/sic_client.sv
module sic_client #(
  parameter int P_TICK_CYC          = sic_pkg::TICK_CYC,
  parameter int P_SPIKE_CYC         = sic_pkg::SPIKE_CYC,
  parameter int P_LOW_TIMEOUT_TICKS = sic_pkg::LOW_TIMEOUT_TCK,
  parameter int P_IDLE_TICKS        = sic_pkg::IDLE_TCK
) (
  input  wire logic                 i_ref_clk,
  input  wire logic                 i_rst_b,
  input  wire logic                 i_bus_clock_pin,
  input  wire logic                 i_sda,
  input  wire sic_pkg::sic_ctrl_t   i_ctrl,
  input  wire logic [7:0]           i_reg_rdata,
  output logic                      o_sda_out,
  output logic                      o_sda_oe,
  output sic_pkg::sic_reg_req_t     o_reg_req,
  output logic                      o_awake
);

  localparam int TICK_W = $clog2(P_TICK_CYC + 1);
  localparam int SPK_W  = $clog2(P_SPIKE_CYC + 1);
  localparam int LOW_W  = $clog2(P_LOW_TIMEOUT_TICKS + 1);
  localparam int IDLE_W = $clog2(P_IDLE_TICKS + 2);
  localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(P_TICK_CYC - 1);
  localparam logic [SPK_W-1:0]  SPK_LAST  = SPK_W'(P_SPIKE_CYC - 1);
  localparam logic [LOW_W-1:0]  LOW_LAST  = LOW_W'(P_LOW_TIMEOUT_TICKS - 1);
  localparam logic [LOW_W-1:0]  LOW_MAX   = LOW_W'(P_LOW_TIMEOUT_TICKS);
  localparam logic [IDLE_W-1:0] IDLE_LAST = IDLE_W'(P_IDLE_TICKS);
  localparam logic [IDLE_W-1:0] IDLE_MAX  = IDLE_W'(P_IDLE_TICKS + 1);

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisation and spike filtering. Bit 0 is clock, bit 1 is data.

  logic [1:0]       pin_sync;
  logic [1:0]       filt_q;
  logic [1:0]       line_q;
  logic [SPK_W-1:0] spk_cnt_q [2];

  sic_sync #(
    .W       (2),
    .RST_VAL (2'h3)
  ) u_sync (
    .i_ref_clk (i_ref_clk),
    .i_rst_b   (i_rst_b),
    .i_async   ({i_sda, i_bus_clock_pin}),
    .o_sync    (pin_sync)
  );

  // A change is accepted only after it has held for the spike window.
  for (genvar b = 0; b < 2; b++) begin : g_filt
    always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
        filt_q[b]    <= 1'b1;
        spk_cnt_q[b] <= '0;
      end else if (pin_sync[b] == filt_q[b]) begin
        spk_cnt_q[b] <= '0;
      end else if (spk_cnt_q[b] == SPK_LAST) begin // RQ12
        filt_q[b]    <= pin_sync[b];
        spk_cnt_q[b] <= '0;
      end else begin
        spk_cnt_q[b] <= spk_cnt_q[b] + SPK_W'(1);
      end
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      line_q <= 2'h3;
    end else begin
      line_q <= filt_q;
    end
  end

  logic scl;
  logic sda;
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;

  // The clock pin is only ever observed; any low time, stretched or not, is
  // waited out, up to the low timeout when that is enabled. RQ8
  assign scl       = filt_q[0];
  assign sda       = filt_q[1];
  assign scl_rise  = scl & ~line_q[0];
  assign scl_fall  = ~scl & line_q[0];
  assign start_det = scl & line_q[0] & line_q[1] & ~sda; // RQ1
  assign stop_det  = scl & line_q[0] & ~line_q[1] & sda; // RQ2

  ////////////////////////////////////////////////////////////////////////////
  // Microsecond tick and the two bus watchdogs.

  logic [TICK_W-1:0] tick_cnt_q;
  logic              tick;
  logic [LOW_W-1:0]  low_cnt_q;
  logic [IDLE_W-1:0] idle_cnt_q;
  logic              low_to;
  logic              idle_to;
  logic              bus_reset;

  assign tick = (tick_cnt_q == TICK_LAST);

  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      tick_cnt_q <= '0;
    end else if (tick) begin
      tick_cnt_q <= '0;
    end else begin
      tick_cnt_q <= tick_cnt_q + TICK_W'(1);
    end
  end

  // Both watchdogs hold at zero unless the timeout option is enabled. RQ10
  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      low_cnt_q <= '0;
    end else if (!i_ctrl.timeout_en || scl) begin
      low_cnt_q <= '0;
    end else if (tick && low_cnt_q != LOW_MAX) begin
      low_cnt_q <= low_cnt_q + LOW_W'(1);
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      idle_cnt_q <= '0;
    end else if (!i_ctrl.timeout_en || !scl || !sda) begin
      idle_cnt_q <= '0;
    end else if (tick && idle_cnt_q != IDLE_MAX) begin
      idle_cnt_q <= idle_cnt_q + IDLE_W'(1);
    end
  end

  assign low_to    = i_ctrl.timeout_en && !scl && tick && low_cnt_q == LOW_LAST; // RQ9
  assign idle_to   = i_ctrl.timeout_en && scl && sda && tick
                     && idle_cnt_q == IDLE_LAST; // RQ11
  assign bus_reset = stop_det | low_to | idle_to; // RQ2

  ////////////////////////////////////////////////////////////////////////////
  // Byte engine decode.

  sic_pkg::sic_state_t st_q;
  logic [3:0]          cnt_q;
  logic [7:0]          shift_q;
  logic [7:0]          tx_q;
  logic [7:0]          rdata_q;
  logic                rd_seen_q;
  logic                dir_q;
  logic                index_seen_q;
  logic                first_rx_q;
  logic [7:0]          ptr_q;
  logic [7:0]          pend_q;
  logic                pend_valid_q;
  logic [7:0]          wr_addr;
  logic                addr_match;
  logic                rd_refused;
  logic                accept;
  logic                byte_fall;
  logic                addr_done;
  logic                rx_done;
  logic                host_ack;

  // The alert response address is excluded explicitly, so it stays unanswered
  // even if the client address is ever changed.
  assign addr_match = (shift_q[7:1] == sic_pkg::CLIENT_ADDR) // RQ4
                      && (shift_q[7:1] != sic_pkg::ALERT_RESP_ADDR); // RQ13
  assign rd_refused = shift_q[0] & i_ctrl.deep_sleep_bit & ~index_seen_q; // RQ20
  assign accept     = addr_match & ~rd_refused;
  assign byte_fall  = scl_fall && (cnt_q == sic_pkg::BITS_PER_BYTE);
  assign addr_done  = (st_q == sic_pkg::ST_ADDR) && byte_fall;
  assign rx_done    = (st_q == sic_pkg::ST_RX) && byte_fall;
  assign host_ack   = (st_q == sic_pkg::ST_TX_ACK) && scl_rise && !sda; // RQ7
  assign wr_addr    = pend_valid_q ? pend_q : ptr_q;

  ////////////////////////////////////////////////////////////////////////////
  // Bus state machine and data line drive.

  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      st_q     <= sic_pkg::ST_IDLE;
      cnt_q    <= '0;
      shift_q  <= '0;
      tx_q     <= '0;
      dir_q    <= 1'b0;
      o_sda_oe <= 1'b0;
    end else if (bus_reset) begin
      st_q     <= sic_pkg::ST_IDLE; // RQ2
      cnt_q    <= '0;
      o_sda_oe <= 1'b0;
    end else if (start_det) begin
      st_q     <= sic_pkg::ST_ADDR; // RQ1
      cnt_q    <= '0;
      o_sda_oe <= 1'b0;
    end else begin
      unique case (st_q)
        sic_pkg::ST_IDLE: begin
          o_sda_oe <= 1'b0;
        end
        sic_pkg::ST_ADDR, sic_pkg::ST_RX: begin
          if (scl_rise) begin
            shift_q <= {shift_q[6:0], sda}; // RQ5
            cnt_q   <= cnt_q + 4'h1;
          end
          if (addr_done) begin
            dir_q <= shift_q[0]; // RQ3
            if (accept) begin
              o_sda_oe <= 1'b1; // RQ6
              st_q     <= sic_pkg::ST_ADDR_ACK;
            end else begin
              st_q <= sic_pkg::ST_IDLE; // RQ25
            end
          end else if (rx_done) begin
            o_sda_oe <= 1'b1; // RQ6
            st_q     <= sic_pkg::ST_RX_ACK;
          end
        end
        sic_pkg::ST_ADDR_ACK: begin
          if (scl_fall) begin
            cnt_q <= '0;
            if (dir_q) begin
              tx_q     <= rdata_q; // RQ19
              o_sda_oe <= ~rdata_q[7];
              st_q     <= sic_pkg::ST_TX;
            end else begin
              o_sda_oe <= 1'b0;
              st_q     <= sic_pkg::ST_RX;
            end
          end
        end
        sic_pkg::ST_RX_ACK: begin
          if (scl_fall) begin
            o_sda_oe <= 1'b0;
            cnt_q    <= '0;
            st_q     <= sic_pkg::ST_RX; // RQ14
          end
        end
        sic_pkg::ST_TX: begin
          if (scl_fall) begin
            if (cnt_q == sic_pkg::LAST_TX_BIT) begin
              o_sda_oe <= 1'b0;
              st_q     <= sic_pkg::ST_TX_ACK;
            end else begin
              tx_q     <= {tx_q[6:0], 1'b0}; // RQ5
              o_sda_oe <= ~tx_q[6];
              cnt_q    <= cnt_q + 4'h1;
            end
          end
        end
        sic_pkg::ST_TX_ACK: begin
          if (scl_rise && sda) begin
            st_q <= sic_pkg::ST_IDLE; // RQ7
          end else if (scl_fall) begin
            tx_q     <= rdata_q; // RQ22
            o_sda_oe <= ~rdata_q[7];
            cnt_q    <= '0;
            st_q     <= sic_pkg::ST_TX;
          end
        end
        default: begin
          st_q     <= sic_pkg::ST_IDLE;
          o_sda_oe <= 1'b0;
        end
      endcase
    end
  end

  // The pin is open drain: it only ever pulls low.
  assign o_sda_out = 1'b0;

  ////////////////////////////////////////////////////////////////////////////
  // Register pointer. Under deep sleep an index is held back and only takes
  // effect once data or a repeated start follows it.

  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      ptr_q        <= sic_pkg::PTR_RESET;
      pend_q       <= sic_pkg::PTR_RESET;
      pend_valid_q <= 1'b0;
      index_seen_q <= 1'b0;
      first_rx_q   <= 1'b0;
    end else if (bus_reset) begin
      pend_valid_q <= 1'b0; // RQ18
      index_seen_q <= 1'b0;
      first_rx_q   <= 1'b0;
    end else if (start_det) begin
      first_rx_q <= 1'b0;
      if (pend_valid_q) begin
        ptr_q        <= pend_q; // RQ16
        pend_valid_q <= 1'b0;
      end
    end else if (addr_done) begin
      first_rx_q <= accept & ~shift_q[0];
    end else if (rx_done) begin
      if (first_rx_q) begin
        first_rx_q   <= 1'b0;
        index_seen_q <= 1'b1;
        if (i_ctrl.deep_sleep_bit) begin
          pend_q       <= shift_q; // RQ18
          pend_valid_q <= 1'b1;
        end else begin
          ptr_q <= shift_q; // RQ17
        end
      end else begin
        ptr_q        <= wr_addr + sic_pkg::PTR_STEP; // RQ23
        pend_valid_q <= 1'b0;
      end
    end else if (host_ack) begin
      ptr_q <= ptr_q + sic_pkg::PTR_STEP; // RQ21
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register file requests and read data capture.

  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_reg_req <= '0;
    end else begin
      o_reg_req.wr <= 1'b0;
      o_reg_req.rd <= 1'b0;
      if (rx_done && !first_rx_q) begin
        o_reg_req.wr    <= 1'b1; // RQ15
        o_reg_req.addr  <= wr_addr;
        o_reg_req.wdata <= shift_q;
      end else if (addr_done && accept && shift_q[0]) begin
        o_reg_req.rd   <= 1'b1; // RQ19
        o_reg_req.addr <= ptr_q;
      end else if (host_ack) begin
        o_reg_req.rd   <= 1'b1; // RQ22
        o_reg_req.addr <= ptr_q + sic_pkg::PTR_STEP;
      end
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rd_seen_q <= 1'b0;
      rdata_q   <= '0;
    end else begin
      rd_seen_q <= o_reg_req.rd;
      if (rd_seen_q) begin
        rdata_q <= i_reg_rdata;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Wake indication: held from an accepted address until the bus is
  // released. The deep sleep bit itself is never touched here.

  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_awake <= 1'b0;
    end else if (bus_reset) begin
      o_awake <= 1'b0;
    end else if (addr_done && accept) begin
      o_awake <= 1'b1; // RQ24
    end
  end

endmodule

// file: rtl/sic_pkg.sv
// Summary of operation
// RQ1: Start is data falling while clock high; it begins a transaction.
// RQ2: Stop is data rising while clock high; it resets the client logic.
// RQ3: First byte after start is a seven-bit address plus direction bit.
// RQ4: The device answers only to client address 0101000, either direction.
// RQ5: Every data byte is eight bits, most significant bit first.
// RQ6: The device acknowledges each received byte in the ninth clock.
// RQ7: A reading host acknowledges every byte except the last one.
// RQ8: The device never stretches the clock and tolerates others stretching it.
// RQ9: With timeout enabled, clock low for 30 ms resets the interface.
// RQ10: The timeout option is disabled after reset; a configuration bit enables it.
// RQ11: With timeout enabled, both lines high over 200 us resets the client.
// RQ12: The interface works for clock rates from 10 kHz to 400 kHz.
// RQ13: The alert response address is never acknowledged.
// RQ14: Multi-byte transfers carry no count byte and have unlimited length.
// RQ15: Write byte stores the data byte at the indexed register.
// RQ16: Read byte sets the index, repeats start, and returns one byte.
// RQ17: Send byte only loads the register pointer.
// RQ18: In deep sleep a send byte does not update the pointer.
// RQ19: Receive byte returns the byte at the current pointer.
// RQ20: In deep sleep a receive byte is not serviced.
// RQ21: Multi-byte reads increment the pointer per byte, wrapping to zero.
// RQ22: Block read returns consecutive registers until the host stops acknowledging.
// RQ23: Block write stores each byte at the pointer, then increments it.
// RQ24: Addressed traffic wakes the device without clearing the deep sleep bit.
// RQ25: A mismatched address is not acknowledged; the bus is ignored until start.
package sic_pkg;

  localparam int          BYTE_W          = 8;
  localparam int          CNT_W           = 4;
  localparam logic [3:0]  BITS_PER_BYTE   = 4'h8;
  localparam logic [3:0]  LAST_TX_BIT     = 4'h7;
  localparam logic [6:0]  CLIENT_ADDR     = 7'h28;
  localparam logic [6:0]  ALERT_RESP_ADDR = 7'h0C;
  localparam logic [7:0]  PTR_RESET       = 8'h00;
  localparam logic [7:0]  PTR_STEP        = 8'h01;

  localparam int          CLK_PERIOD_NS   = 10;
  localparam int          TICK_NS         = 1000;
  localparam int          TICK_CYC        = TICK_NS / CLK_PERIOD_NS;
  localparam int          SPIKE_NS        = 50;
  localparam int          SPIKE_CYC       = SPIKE_NS / CLK_PERIOD_NS;
  localparam int          LOW_TIMEOUT_MS  = 30;
  localparam int          LOW_TIMEOUT_TCK = LOW_TIMEOUT_MS * 1000 * 1000 / TICK_NS;
  localparam int          IDLE_US         = 200;
  localparam int          IDLE_TCK        = IDLE_US * 1000 / TICK_NS;

  typedef enum logic [2:0] {
    ST_IDLE     = 3'b000,
    ST_ADDR     = 3'b001,
    ST_ADDR_ACK = 3'b010,
    ST_RX       = 3'b011,
    ST_RX_ACK   = 3'b100,
    ST_TX       = 3'b101,
    ST_TX_ACK   = 3'b110
  } sic_state_t;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } sic_reg_req_t;

  typedef struct packed {
    logic timeout_en;
    logic deep_sleep_bit;
  } sic_ctrl_t;

endpackage

// file: rtl/sic_sync.sv
module sic_sync #(
  parameter int         W       = 2,
  parameter logic [1:0] RST_VAL = 2'h3
) (
  input  wire logic         i_ref_clk,
  input  wire logic         i_rst_b,
  input  wire logic [W-1:0] i_async,
  output logic      [W-1:0] o_sync
);

  logic [W-1:0] meta_q;

  // The first stage feeds only the second stage.
  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      meta_q <= RST_VAL;
      o_sync <= RST_VAL;
    end else begin
      meta_q <= i_async;
      o_sync <= meta_q;
    end
  end

endmodule

// file: tb/sic_client_sva.sv
module sic_client_sva (
  input wire logic                  i_ref_clk,
  input wire logic                  i_rst_b,
  input wire logic                  i_bus_clock_pin,
  input wire logic                  i_sda,
  input wire sic_pkg::sic_ctrl_t    i_ctrl,
  input wire logic [7:0]            i_reg_rdata,
  input wire logic                  o_sda_out,
  input wire logic                  o_sda_oe,
  input wire sic_pkg::sic_reg_req_t o_reg_req,
  input wire logic                  o_awake
);
  timeunit 1ns;
  timeprecision 1ps;

  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (!i_rst_b);

  logic [7:0] wr_last_q;
  logic [7:0] rd_last_q;
  logic       wr_seen_q;
  logic       rd_seen_q;
  logic       awake_q;
  logic       sda_q;
  logic       restart;

  // A start on the pins opens a new index, so the step checks begin afresh there.
  assign restart = (awake_q && !o_awake) || (sda_q && !i_sda && i_bus_clock_pin);

  // Remembers the last request addresses and forgets them when a transaction ends.
  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      wr_last_q <= 8'h00;
      rd_last_q <= 8'h00;
      wr_seen_q <= 1'b0;
      rd_seen_q <= 1'b0;
      awake_q   <= 1'b0;
      sda_q     <= 1'b1;
    end else begin
      awake_q <= o_awake;
      sda_q   <= i_sda;
      if (o_reg_req.wr) begin
        wr_last_q <= o_reg_req.addr;
        wr_seen_q <= 1'b1;
      end else if (restart) begin
        wr_seen_q <= 1'b0;
      end
      if (o_reg_req.rd) begin
        rd_last_q <= o_reg_req.addr;
        rd_seen_q <= 1'b1;
      end else if (restart) begin
        rd_seen_q <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////
  chk_oe_scl_low: assert property ($changed(o_sda_oe) |-> !i_bus_clock_pin)
    else $error("data drive changed while clock high");
  chk_ack_hold: assert property ($rose(o_sda_oe) |=> o_sda_oe [*8])
    else $error("data drive released too early");
  chk_wr_acked: assert property (o_reg_req.wr |-> ##[0:1] o_sda_oe)
    else $error("register write without acknowledge");
  chk_wr_single: assert property (o_reg_req.wr |=> !o_reg_req.wr [*8])
    else $error("register write pulse repeated");
  chk_wr_step: assert property (
    o_reg_req.wr && wr_seen_q |-> o_reg_req.addr == wr_last_q + 8'h01)
    else $error("write address did not step by one");
  chk_rd_step: assert property (
    o_reg_req.rd && rd_seen_q |-> o_reg_req.addr == rd_last_q + 8'h01)
    else $error("read address did not step by one");
  chk_stop_ends: assert property (
    $rose(i_sda) && i_bus_clock_pin |-> ##[1:16] !o_awake)
    else $error("stop did not end the transaction");
  chk_drop_cause: assert property (
    $fell(o_awake) && !i_ctrl.timeout_en |-> i_bus_clock_pin)
    else $error("transaction ended without stop");
  chk_oe_awake: assert property (o_sda_oe && $past(o_sda_oe) |-> o_awake)
    else $error("data driven outside an accepted transaction");

  cover property (o_reg_req.wr);
  cover property (o_reg_req.rd);
  cover property ($fell(o_awake) && i_ctrl.timeout_en);
endmodule

// file: tb/sic_host.sv
module sic_host (
  input  wire logic i_ref_clk,
  input  wire logic i_sda,
  output logic      o_scl,
  output logic      o_sda
);
  timeunit 1ns;
  timeprecision 1ps;

  // High phase and data hold after the fall; one bit takes 251 cycles, just under 400 kHz.
  localparam int HIGH = 115;
  localparam int HOLD = 20;

  initial begin
    o_scl = 1'b1;
    o_sda = 1'b1;
  end

  ////////////////////////////////////////
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge i_ref_clk);
  endtask

  // Sets the data line while the clock is low, then pulses the clock and samples the line.
  task automatic clk_bit(input logic b, input int high, output logic s);
    @(posedge i_ref_clk);
    o_sda <= b;
    wait_cyc(HIGH);
    o_scl <= 1'b1;
    wait_cyc(high);
    s = i_sda;
    o_scl <= 1'b0;
    wait_cyc(HOLD);
  endtask

  task automatic send_start();
    @(posedge i_ref_clk);
    o_sda <= 1'b1;
    wait_cyc(HIGH);
    o_scl <= 1'b1;
    wait_cyc(HIGH);
    o_sda <= 1'b0;
    wait_cyc(HIGH);
    o_scl <= 1'b0;
  endtask

  task automatic send_stop();
    @(posedge i_ref_clk);
    o_sda <= 1'b0;
    wait_cyc(HIGH);
    o_scl <= 1'b1;
    wait_cyc(HIGH);
    o_sda <= 1'b1;
    wait_cyc(HIGH);
  endtask

  task automatic wr_byte(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      clk_bit(d[i], HIGH, s);
    end
    clk_bit(1'b1, HIGH, s);
    ack = ~s;
  endtask

  task automatic rd_byte(input logic ack, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      clk_bit(1'b1, HIGH, s);
      d[i] = s;
    end
    clk_bit(~ack, HIGH, s);
  endtask
endmodule

// file: tb/smbus_i2c_client_port_test.sv
module smbus_i2c_client_port_test;
  timeunit 1ns;
  timeprecision 1ps;

  localparam logic [6:0] DEV = 7'h28;

  logic                  clk;
  logic                  rst_b;
  logic                  scl;
  logic                  host_sda;
  logic                  sda_line;
  sic_pkg::sic_ctrl_t    ctrl;
  logic [7:0]            rdata;
  logic                  sda_out;
  logic                  sda_oe;
  sic_pkg::sic_reg_req_t req;
  logic                  awake;
  logic [7:0]            mem [256];
  int                    err_count;
  int                    checks;

  // The data line has a pull-up: it is low only while someone pulls it, and
  // the device pulls it low while enabled and its data output is low.
  assign sda_line = host_sda & ~(sda_oe & ~sda_out);

  sic_client #(
    .P_TICK_CYC(10),
    .P_SPIKE_CYC(5),
    .P_LOW_TIMEOUT_TICKS(40),
    .P_IDLE_TICKS(16)
  ) i_dut (
    .i_ref_clk(clk), .i_rst_b(rst_b), .i_bus_clock_pin(scl), .i_sda(sda_line),
    .i_ctrl(ctrl), .i_reg_rdata(rdata), .o_sda_out(sda_out), .o_sda_oe(sda_oe),
    .o_reg_req(req), .o_awake(awake)
  );

  sic_host i_host (.i_ref_clk(clk), .i_sda(sda_line), .o_scl(scl), .o_sda(host_sda));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  always @(posedge clk) begin
    if (req.wr)
      mem[req.addr] <= req.wdata;
    if (req.rd)
      rdata <= mem[req.addr];
  end

  ////////////////////////////////////////
  function automatic logic [7:0] pat(input logic [7:0] a);
    return a ^ 8'h5A;
  endfunction

  task automatic cmp_bit(input logic got, input logic exp);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %0t got %0h exp %0h", $time, got, exp);
    end
  endtask

  task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %0t got %0h exp %0h", $time, got, exp);
    end
  endtask

  task automatic test_done();
    if (err_count == 0 && checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic xfer(input logic [7:0] b, input logic exp);
    logic a;
    i_host.wr_byte(b, a);
    cmp_bit(a, exp);
  endtask

  ////////////////////////////////////////
  task automatic t_block_write();
    i_host.send_start();
    xfer({DEV, 1'b0}, 1'b1);
    xfer(8'hFE, 1'b1);
    for (int k = 0; k < 3; k++) begin
      xfer(8'hC0 + 8'(k), 1'b1);
    end
    i_host.send_stop();
    cmp_byte(mem[8'hFE], 8'hC0);
    cmp_byte(mem[8'hFF], 8'hC1);
    cmp_byte(mem[8'h00], 8'hC2);
  endtask

  task automatic t_block_read();
    logic [7:0] d;
    i_host.send_start();
    xfer({DEV, 1'b0}, 1'b1);
    xfer(8'hFF, 1'b1);
    i_host.send_start();
    xfer({DEV, 1'b1}, 1'b1);
    i_host.rd_byte(1'b1, d);
    cmp_byte(d, 8'hC1);
    i_host.rd_byte(1'b1, d);
    cmp_byte(d, 8'hC2);
    i_host.rd_byte(1'b0, d);
    cmp_byte(d, pat(8'h01));
    i_host.send_stop();
  endtask

  task automatic t_send_recv();
    logic [7:0] d;
    i_host.send_start();
    xfer({DEV, 1'b0}, 1'b1);
    xfer(8'h10, 1'b1);
    i_host.send_stop();
    repeat (2) begin
      i_host.send_start();
      xfer({DEV, 1'b1}, 1'b1);
      i_host.rd_byte(1'b0, d);
      cmp_byte(d, pat(8'h10));
      i_host.send_stop();
    end
  endtask

  task automatic t_bad_addr();
    logic [7:0] bad [3];
    bad = '{8'h18, 8'h19, 8'h52};
    foreach (bad[i]) begin
      i_host.send_start();
      xfer(bad[i], 1'b0);
      xfer({DEV, 1'b0}, 1'b0);
      i_host.send_stop();
    end
  endtask

  task automatic t_deep_sleep();
    logic [7:0] d;
    @(posedge clk);
    ctrl.deep_sleep_bit <= 1'b1;
    i_host.send_start();
    xfer({DEV, 1'b1}, 1'b0);
    i_host.send_stop();
    i_host.send_start();
    xfer({DEV, 1'b0}, 1'b1);
    xfer(8'h30, 1'b1);
    xfer(8'h3C, 1'b1);
    cmp_bit(awake, 1'b1);
    i_host.send_stop();
    cmp_bit(awake, 1'b0);
    cmp_byte(mem[8'h30], 8'h3C);
    i_host.send_start();
    xfer({DEV, 1'b0}, 1'b1);
    xfer(8'h40, 1'b1);
    i_host.send_stop();
    @(posedge clk);
    ctrl.deep_sleep_bit <= 1'b0;
    i_host.send_start();
    xfer({DEV, 1'b1}, 1'b1);
    i_host.rd_byte(1'b0, d);
    cmp_byte(d, pat(8'h31));
    i_host.send_stop();
  endtask

  task automatic t_timeouts();
    logic s;
    for (int en = 0; en < 2; en++) begin
      @(posedge clk);
      ctrl.timeout_en <= en[0];
      i_host.send_start();
      xfer({DEV, 1'b0}, 1'b1);
      i_host.wait_cyc(600);
      cmp_bit(awake, ~en[0]);
      i_host.send_stop();
      i_host.send_start();
      xfer({DEV, 1'b0}, 1'b1);
      i_host.clk_bit(1'b1, 400, s);
      cmp_bit(awake, ~en[0]);
      i_host.send_stop();
    end
    @(posedge clk);
    ctrl.timeout_en <= 1'b0;
  endtask

  ////////////////////////////////////////
  initial begin
    err_count = 0;
    checks = 0;
    rst_b = 1'b0;
    ctrl = '0;
    rdata = 8'h00;
    for (int i = 0; i < 256; i++) begin
      mem[i] = pat(8'(i));
    end
    repeat (5) @(posedge clk);
    cmp_bit(sda_oe, 1'b0);
    cmp_bit(awake, 1'b0);
    rst_b <= 1'b1;
    repeat (10) @(posedge clk);
    t_block_write();
    t_block_read();
    t_send_recv();
    t_bad_addr();
    t_deep_sleep();
    t_timeouts();
    test_done();
  end

  initial begin
    repeat (100000) @(posedge clk);
    err_count++;
    test_done();
  end
endmodule

bind sic_client sic_client_sva i_chk (
  .i_ref_clk(i_ref_clk), .i_rst_b(i_rst_b), .i_bus_clock_pin(i_bus_clock_pin),
  .i_sda(i_sda), .i_ctrl(i_ctrl), .i_reg_rdata(i_reg_rdata), .o_sda_out(o_sda_out),
  .o_sda_oe(o_sda_oe), .o_reg_req(o_reg_req), .o_awake(o_awake)
);
